// ==== rtl/temp_sensor_regs_alarm.sv ====
`timescale 1ns/1ns
// Function
// - four registers by pointer: temperature 0, config 1, hysteresis 2, over-limit 3
// - reset values: config 00, hysteresis 4B0, over-limit 500; temperature read only
// - temperature is 9-bit two's complement in D15..D7, LSB half degree
// - temperature read gives upper byte then lower byte, MSB first
// - low seven temperature bits are meaningless; host ignores them
// - clip readings above +127.5 to 7F8h, below -64 to BF8h
// - freeze temperature during its read; next conversion after the read updates
// - config D4:D3 select fault count 1, 2, 4 or 6
// - config D2 selects alarm polarity; alarm pin is always open drain
// - comparator mode: assert above over-limit, release below hysteresis
// - interrupt mode: assert on crossing, hold until any read, then alternate
// - entering shutdown clears the interrupt-mode alarm
// - config D0 stops conversions; link and registers stay usable
// - limits hold D15..D7; D6..D0 ignored on write, read as zero
// - pointer keeps last written value, resets to temperature
// - single limit data byte lands in D15..D8; bytes after second dropped
// - second config byte replaces first; further bytes ignored
// - answer only bus address 1001 plus address-select pins
module temp_sensor_regs_alarm
	import temp_sensor_pkg::*;
(
	input wire logic core_clk_i, // system clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic adc_clk_i, // converter clock
	input wire logic adc_valid_i, // conversion done pulse
	input wire logic [11:0] adc_temp_i, // signed half degrees
	input wire logic scl_i, // serial clock pin
	input wire logic sda_i, // serial data pin level
	output logic sda_o, // serial data drive level
	output logic sda_oe_o, // serial data pull low
	input wire logic addr_select_bit0_i, // address strap
	input wire logic addr_select_bit1_i, // address strap
	input wire logic addr_select_bit2_i, // address strap
	output logic overtemp_alarm_out_o, // alarm drive level
	output logic overtemp_alarm_oe_o // alarm pull low
);
	import temp_sensor_pkg::*;

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	logic [4:0] pin_m;
	logic [4:0] pin_s;
	logic scl_q;
	logic sda_q;
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pin_m <= 5'h03;
			pin_s <= 5'h03;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			pin_m <= {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i, scl_i, sda_i};
			pin_s <= pin_m;
			scl_q <= pin_s[1];
			sda_q <= pin_s[0];
		end
	end
	wire scl_s = pin_s[1];
	wire sda_s = pin_s[0];
	wire [2:0] addr_pins = pin_s[4:2];
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

	// ****************************************************
	// link state and registers
	// ****************************************************
	link_state_e state;
	logic [2:0] bit_cnt;
	logic [2:0] byte_idx;
	logic [7:0] shift;
	logic rd_mode;
	logic got_byte;
	logic ack_go;
	logic tx_lo;
	logic [1:0] ptr;
	logic [7:0] cfg;
	logic [8:0] hyst;
	logic [8:0] over;
	logic [11:0] temp_code;

	wire [7:0] rx_byte = {shift[6:0], sda_s};
	wire byte_done = (state == st_rx) && scl_rise && (bit_cnt == 3'h7);
	wire addr_hit = (rx_byte[7:4] == BUS_ADDR_HI) && (rx_byte[3:1] == addr_pins);
	wire wr_data = byte_done && !rd_mode &&
		(byte_idx == BYTE_DATA_HI || byte_idx == BYTE_DATA_LO);
	wire cfg_we = wr_data && (ptr == PTR_CFG);
	wire hi_we = wr_data && (byte_idx == BYTE_DATA_HI);
	wire lo_we = wr_data && (byte_idx == BYTE_DATA_LO);
	wire ptr_we = byte_done && !rd_mode && (byte_idx == BYTE_PTR);
	wire [8:0] lim_sel = (ptr == PTR_HYST) ? hyst : over;
	wire [15:0] sel_word = (ptr == PTR_TEMP) ? {temp_code, 4'h0} :
		(ptr == PTR_CFG) ? {cfg, cfg} : {lim_sel, 7'h00};
	wire [7:0] tx_byte = tx_lo ? sel_word[7:0] : sel_word[15:8];
	wire load_tx = ((state == st_ack) && rd_mode && scl_fall) ||
		((state == st_rack) && scl_fall && got_byte);
	wire read_done = ((state == st_rack) && scl_rise && sda_s) ||
		(stop_cond && rd_mode && state != st_idle);
	wire temp_busy = rd_mode && (ptr == PTR_TEMP) &&
		(state == st_ack || state == st_tx || state == st_rack);
	wire shutdown_entry = cfg_we && rx_byte[CFG_SHUTDOWN] && !cfg[CFG_SHUTDOWN];

	// ****************************************************
	// byte engine
	// ****************************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= st_idle;
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
			shift <= 8'h00;
			rd_mode <= 1'b0;
			got_byte <= 1'b0;
			ack_go <= 1'b0;
			tx_lo <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else if (start_cond)
		begin
			state <= st_rx;
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
			got_byte <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else if (stop_cond)
		begin
			state <= st_idle;
			sda_oe_o <= 1'b0;
		end
		else if (load_tx)
		begin
			state <= st_tx;
			shift <= tx_byte;
			sda_oe_o <= ~tx_byte[7];
			tx_lo <= ~tx_lo;
			bit_cnt <= 3'h0;
			got_byte <= 1'b0;
		end
		else
		begin
			case (state)
				st_rx:
				begin
					if (scl_rise)
					begin
						shift <= rx_byte;
						bit_cnt <= bit_cnt + 3'h1;
					end
					if (byte_done)
					begin
						got_byte <= 1'b1;
						ack_go <= (byte_idx != 3'h0) || addr_hit;
						if (byte_idx == 3'h0)
						begin
							rd_mode <= rx_byte[0];
							tx_lo <= 1'b0;
						end
					end
					if (scl_fall && got_byte)
					begin
						got_byte <= 1'b0;
						state <= ack_go ? st_ack : st_idle;
						sda_oe_o <= ack_go;
						if (byte_idx != BYTE_EXTRA)
						begin
							byte_idx <= byte_idx + 3'h1;
						end
					end
				end
				st_ack:
				begin
					if (scl_fall)
					begin
						state <= st_rx;
						sda_oe_o <= 1'b0;
					end
				end
				st_tx:
				begin
					if (scl_fall && bit_cnt == 3'h7)
					begin
						state <= st_rack;
						sda_oe_o <= 1'b0;
					end
					else if (scl_fall)
					begin
						shift <= {shift[6:0], 1'b0};
						sda_oe_o <= ~shift[6];
						bit_cnt <= bit_cnt + 3'h1;
					end
				end
				st_rack:
				begin
					if (scl_rise && sda_s)
					begin
						state <= st_idle;
					end
					else if (scl_rise)
					begin
						got_byte <= 1'b1;
					end
				end
				default:
				begin
					state <= st_idle;
				end
			endcase
		end
	end

	// ****************************************************
	// register writes
	// ****************************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ptr <= PTR_TEMP;
			cfg <= CFG_RESET;
			hyst <= HYST_RESET[11:3];
			over <= OVER_RESET[11:3];
		end
		else
		begin
			if (ptr_we)
			begin
				ptr <= rx_byte[1:0];
			end
			if (cfg_we)
			begin
				cfg <= rx_byte;
			end
			if (hi_we && ptr == PTR_HYST)
			begin
				hyst <= {rx_byte, 1'b0};
			end
			if (lo_we && ptr == PTR_HYST)
			begin
				hyst[0] <= rx_byte[7];
			end
			if (hi_we && ptr == PTR_OVER)
			begin
				over <= {rx_byte, 1'b0};
			end
			if (lo_we && ptr == PTR_OVER)
			begin
				over[0] <= rx_byte[7];
			end
		end
	end

	// ****************************************************
	// converter side: clip, hold, toggle handshake
	// ****************************************************
	logic conv_req;
	logic [11:0] conv_hold;
	logic ack_m;
	logic ack_s;
	logic req_m;
	logic req_s;
	logic conv_ack;
	wire adc_free = (conv_req == ack_s);
	wire [11:0] clip_code = ($signed(adc_temp_i) > TEMP_MAX) ? TEMP_SAT_HI :
		($signed(adc_temp_i) < TEMP_MIN) ? TEMP_SAT_LO : {adc_temp_i[8:0], 3'h0};
	always_ff @(posedge adc_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			conv_req <= 1'b0;
			conv_hold <= TEMP_RESET;
			ack_m <= 1'b0;
			ack_s <= 1'b0;
		end
		else
		begin
			ack_m <= conv_ack;
			ack_s <= ack_m;
			if (adc_valid_i && adc_free)
			begin
				conv_hold <= clip_code;
				conv_req <= ~conv_req;
			end
		end
	end

	// ****************************************************
	// alarm logic
	// ****************************************************
	logic await_under;
	logic int_flag;
	logic [2:0] fault_cnt;
	wire new_conv = (req_s != conv_ack);
	wire take = new_conv && !cfg[CFG_SHUTDOWN] && !temp_busy;
	wire signed [8:0] conv_val = conv_hold[11:3];
	wire trip_cond = await_under ? (conv_val < $signed(hyst)) :
		(conv_val > $signed(over));
	wire [1:0] queue = cfg[CFG_QUEUE_HI:CFG_QUEUE_LO];
	wire [2:0] need = (queue == 2'h0) ? FAULTS_Q0 : (queue == 2'h1) ? FAULTS_Q1 :
		(queue == 2'h2) ? FAULTS_Q2 : FAULTS_Q3;
	wire [2:0] next_faults = fault_cnt + 3'h1;
	wire trip = take && trip_cond && (next_faults >= need);
	wire alarm = cfg[CFG_INT_MODE] ? int_flag : await_under;
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			conv_ack <= 1'b0;
			temp_code <= TEMP_RESET;
			fault_cnt <= 3'h0;
			await_under <= 1'b0;
			int_flag <= 1'b0;
			sda_o <= 1'b0;
			overtemp_alarm_out_o <= 1'b0;
			overtemp_alarm_oe_o <= 1'b0;
		end
		else
		begin
			req_m <= conv_req;
			req_s <= req_m;
			conv_ack <= req_s;
			sda_o <= 1'b0;
			overtemp_alarm_out_o <= 1'b0;
			overtemp_alarm_oe_o <= alarm ^ cfg[CFG_POLARITY];
			if (take)
			begin
				temp_code <= conv_hold;
				fault_cnt <= (trip_cond && !trip) ? next_faults : 3'h0;
			end
			if (trip)
			begin
				await_under <= ~await_under;
			end
			// a trip landing on the shutdown write does not set the flag, so shutdown always clears
			int_flag <= (int_flag && !read_done && !shutdown_entry) ||
				(trip && cfg[CFG_INT_MODE] && !shutdown_entry);
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	freeze_temp_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		temp_busy |=> $stable(temp_code)) else $error("temperature changed during read");
	shutdown_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(cfg[CFG_SHUTDOWN]) |-> !int_flag) else $error("alarm kept on shutdown");
	limit_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		ptr[1] |-> sel_word[6:0] == 7'h00) else $error("limit low bits not zero");
	alarm_polarity_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		1'b1 |=> overtemp_alarm_oe_o == ($past(alarm) ^ $past(cfg[CFG_POLARITY])))
		else $error("alarm pin drive wrong");
	fault_bound_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		take && !trip_cond |=> fault_cnt == 3'h0) else $error("fault count not restarted");
	int_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		int_flag && !read_done && !shutdown_entry |=> int_flag)
		else $error("interrupt alarm dropped without read");
	comp_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!take |=> $stable(await_under)) else $error("alarm state moved without conversion");
	ptr_keep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!ptr_we |=> $stable(ptr)) else $error("pointer changed without pointer byte");
	sat_high_a: assert property (@(posedge adc_clk_i) disable iff (!reset_n_i)
		adc_valid_i && adc_free && ($signed(adc_temp_i) > TEMP_MAX) |=>
		conv_hold == TEMP_SAT_HI) else $error("high reading not clipped");
endmodule : temp_sensor_regs_alarm

// ==== rtl/temp_sensor_pkg.sv ====
package temp_sensor_pkg;
	// ****************************************************
	// register pointers
	// ****************************************************
	localparam logic [1:0] PTR_TEMP = 2'h0;
	localparam logic [1:0] PTR_CFG = 2'h1;
	localparam logic [1:0] PTR_HYST = 2'h2;
	localparam logic [1:0] PTR_OVER = 2'h3;
	// ****************************************************
	// reset values and saturation codes, 12-bit register codes except the 8-bit config
	// ****************************************************
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [11:0] HYST_RESET = 12'h04b0;
	localparam logic [11:0] OVER_RESET = 12'h0500;
	localparam logic [11:0] TEMP_RESET = 12'h0000;
	localparam logic [11:0] TEMP_SAT_HI = 12'h07f8;
	localparam logic [11:0] TEMP_SAT_LO = 12'h0bf8;
	// converter range in half degrees
	localparam logic signed [11:0] TEMP_MAX = 12'sh00ff;
	localparam logic signed [11:0] TEMP_MIN = 12'sh0f80;
	// ****************************************************
	// configuration fields
	// ****************************************************
	localparam int CFG_SHUTDOWN = 0;
	localparam int CFG_INT_MODE = 1;
	localparam int CFG_POLARITY = 2;
	localparam int CFG_QUEUE_LO = 3;
	localparam int CFG_QUEUE_HI = 4;
	localparam logic [2:0] FAULTS_Q0 = 3'h1;
	localparam logic [2:0] FAULTS_Q1 = 3'h2;
	localparam logic [2:0] FAULTS_Q2 = 3'h4;
	localparam logic [2:0] FAULTS_Q3 = 3'h6;
	// ****************************************************
	// serial link
	// ****************************************************
	localparam logic [3:0] BUS_ADDR_HI = 4'h9;
	localparam logic [2:0] BYTE_PTR = 3'h1;
	localparam logic [2:0] BYTE_DATA_HI = 3'h2;
	localparam logic [2:0] BYTE_DATA_LO = 3'h3;
	localparam logic [2:0] BYTE_EXTRA = 3'h4;
	typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_rack} link_state_e;
endpackage : temp_sensor_pkg

// ==== verif/i2c_host_model.sv ====
`timescale 1ns/1ns
module i2c_host_model
#(
	parameter int half_cyc = 10
)
(
	input wire logic clk_i, // core clock
	input wire logic sda_i, // resolved data line
	output logic scl_o, // serial clock drive
	output logic sda_o // data drive, 1 = release
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// ****************************************************
	// bus conditions, also used as repeated start
	// ****************************************************
	task start;
		sda_o <= 1'b1;
		tick(half_cyc);
		scl_o <= 1'b1;
		tick(half_cyc);
		sda_o <= 1'b0;
		tick(half_cyc);
		scl_o <= 1'b0;
		tick(half_cyc);
	endtask : start
	task stop;
		sda_o <= 1'b0;
		tick(half_cyc);
		scl_o <= 1'b1;
		tick(half_cyc);
		sda_o <= 1'b1;
		tick(half_cyc);
	endtask : stop
	// ****************************************************
	// one bit: data moves 2 cycles after scl fall
	// ****************************************************
	task clk_bit(input logic b, output logic r);
		sda_o <= b;
		tick(half_cyc);
		scl_o <= 1'b1;
		tick(half_cyc / 2);
		r = sda_i;
		tick(half_cyc / 2);
		scl_o <= 1'b0;
		tick(2);
	endtask : clk_bit
	task wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 0; i < 8; i++)
			clk_bit(d[7-i], r);
		clk_bit(1'b1, r);
		ack = !r;
	endtask : wr
	task rd(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 0; i < 8; i++)
		begin
			clk_bit(1'b1, r);
			d[7-i] = r;
		end
		clk_bit(!ack, r);
	endtask : rd
endmodule : i2c_host_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	import temp_sensor_pkg::*;
	logic core_clk = 1'b0;
	logic adc_clk = 1'b0;
	logic reset_n = 1'b0;
	logic adc_valid = 1'b0;
	logic [11:0] adc_temp = 12'h000;
	logic scl, host_sda, sda_drv, sda_oe, alarm_out, alarm_oe;
	wire sda_wire = host_sda & ~sda_oe;
	logic [6:0] dev_addr = {BUS_ADDR_HI, 3'b101};
	int failures = 0;
	int checks = 0;
	int faults [4] = '{1, 2, 4, 6};
	logic [11:0] tin [4] = '{12'h032, 12'h12c, 12'hf38, 12'hfff};
	logic [15:0] tout [4] = '{16'h1900, 16'h7f80, 16'hbf80, 16'hff80};
	always #50 core_clk = ~core_clk;
	always #16 adc_clk = ~adc_clk;
	temp_sensor_regs_alarm uut (.core_clk_i(core_clk), .reset_n_i(reset_n),
		.adc_clk_i(adc_clk), .adc_valid_i(adc_valid), .adc_temp_i(adc_temp),
		.scl_i(scl), .sda_i(sda_wire), .sda_o(sda_drv), .sda_oe_o(sda_oe),
		.addr_select_bit0_i(1'b1), .addr_select_bit1_i(1'b0), .addr_select_bit2_i(1'b1),
		.overtemp_alarm_out_o(alarm_out), .overtemp_alarm_oe_o(alarm_oe));
	i2c_host_model host (.clk_i(core_clk), .sda_i(sda_wire), .scl_o(scl), .sda_o(host_sda));
	// ****************************************************
	// checking and bus tasks
	// ****************************************************
	task end_sim;
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task send(input logic [7:0] b, input logic want);
		logic ack;
		host.wr(b, ack);
		chk("ack", {15'h0, want}, {15'h0, ack});
	endtask : send
	task wreg(input logic [1:0] ptr, input int n, input logic [23:0] d);
		host.start;
		send({dev_addr, 1'b0}, 1'b1);
		send({6'h0, ptr}, 1'b1);
		for (int i = 0; i < n; i++)
			send(d[23-8*i -: 8], 1'b1);
		host.stop;
	endtask : wreg
	task rchk(input string what, input bit setp, input logic [1:0] ptr,
		input logic [15:0] exp, input logic [15:0] mask);
		logic [15:0] v;
		host.start;
		if (setp)
		begin
			send({dev_addr, 1'b0}, 1'b1);
			send({6'h0, ptr}, 1'b1);
			host.start;
		end
		send({dev_addr, 1'b1}, 1'b1);
		host.rd(v[15:8], 1'b1);
		host.rd(v[7:0], 1'b0);
		host.stop;
		chk(what, exp, v & mask);
	endtask : rchk
	task conv(input logic [11:0] t);
		@(posedge adc_clk);
		adc_valid <= 1'b1;
		adc_temp <= t;
		@(posedge adc_clk);
		adc_valid <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask : conv
	task alarm(input logic exp);
		chk("alarm_oe", {15'h0, exp}, {15'h0, alarm_oe});
	endtask : alarm
	// ****************************************************
	// test sequence
	// ****************************************************
	initial
	begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rchk("temp_nop", 0, PTR_TEMP, 16'h0000, 16'hffff);
		rchk("config", 1, PTR_CFG, 16'h0000, 16'hffff);
		rchk("hyst", 1, PTR_HYST, 16'h4b00, 16'hffff);
		rchk("over", 1, PTR_OVER, 16'h5000, 16'hffff);
		wreg(PTR_TEMP, 2, 24'h1234_00);
		rchk("temp_ro", 1, PTR_TEMP, 16'h0000, 16'hffff);
		wreg(PTR_HYST, 2, 24'h19ff_00);
		rchk("hyst_wr", 1, PTR_HYST, 16'h1980, 16'hffff);
		wreg(PTR_OVER, 1, 24'h55_0000);
		rchk("over_one", 1, PTR_OVER, 16'h5500, 16'hffff);
		wreg(PTR_OVER, 3, 24'h6080_ff);
		rchk("over_three", 0, PTR_OVER, 16'h6080, 16'hffff);
		wreg(PTR_CFG, 2, 24'h0402_00);
		rchk("cfg_two", 1, PTR_CFG, 16'h0202, 16'hffff);
		host.start;
		send({dev_addr ^ 7'h08, 1'b0}, 1'b0);
		host.stop;
		host.start;
		send({dev_addr ^ 7'h01, 1'b0}, 1'b0);
		host.stop;
		wreg(PTR_HYST, 2, 24'h4b00_00);
		wreg(PTR_OVER, 2, 24'h5000_00);
		wreg(PTR_CFG, 1, 24'h00_0000);
		for (int i = 0; i < 4; i++)
		begin
			conv(tin[i]);
			rchk("temp", 1, PTR_TEMP, tout[i], 16'hff80);
		end
		fork
			rchk("temp_frozen", 1, PTR_TEMP, 16'hff80, 16'hff80);
			begin
				repeat (950) @(posedge core_clk);
				conv(12'h03c);
			end
		join
		rchk("temp_held", 0, PTR_TEMP, 16'hff80, 16'hff80);
		conv(12'h03c);
		rchk("temp_next", 0, PTR_TEMP, 16'h1e00, 16'hff80);
		conv(12'h0aa);
		alarm(1'b1);
		conv(12'h09b);
		alarm(1'b1);
		conv(12'h08c);
		alarm(1'b0);
		wreg(PTR_CFG, 1, 24'h04_0000);
		alarm(1'b1);
		conv(12'h0aa);
		alarm(1'b0);
		conv(12'h08c);
		for (int q = 0; q < 4; q++)
		begin
			wreg(PTR_CFG, 1, {3'b000, q[1:0], 3'b000, 16'h0000});
			repeat (faults[q] - 1) conv(12'h0aa);
			conv(12'h09b);
			repeat (faults[q] - 1) conv(12'h0aa);
			alarm(1'b0);
			conv(12'h0aa);
			alarm(1'b1);
			repeat (faults[q]) conv(12'h08c);
			alarm(1'b0);
		end
		wreg(PTR_CFG, 1, 24'h02_0000);
		conv(12'h0aa);
		alarm(1'b1);
		rchk("hyst_int", 1, PTR_HYST, 16'h4b00, 16'hffff);
		alarm(1'b0);
		conv(12'h0aa);
		alarm(1'b0);
		conv(12'h08c);
		alarm(1'b1);
		rchk("over_int", 1, PTR_OVER, 16'h5000, 16'hffff);
		alarm(1'b0);
		conv(12'h0aa);
		alarm(1'b1);
		wreg(PTR_CFG, 1, 24'h03_0000);
		alarm(1'b0);
		conv(12'h03c);
		rchk("temp_sd", 1, PTR_TEMP, 16'h5500, 16'hff80);
		wreg(PTR_HYST, 2, 24'h3280_00);
		rchk("hyst_sd", 1, PTR_HYST, 16'h3280, 16'hffff);
		chk("drive_levels", 16'h0000, {14'h0, sda_drv, alarm_out});
		end_sim;
	end
	initial
	begin
		repeat (90000) @(posedge core_clk);
		failures++;
		end_sim;
	end
endmodule : tb_top
